// *** rtl/mss_defs.vh ***
// Register map, field layout, reset values and timing for the start sequencer
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH
`define MSS_OFS_CTRL 8'h00
`define MSS_OFS_CFG 8'h04
`define MSS_OFS_START_FREQ 8'h08
`define MSS_OFS_HOLD_TIME 8'h0C
`define MSS_OFS_BRAKE_EXCITE 8'h10
`define MSS_OFS_SCURVE 8'h14
`define MSS_OFS_TARGET 8'h18
`define MSS_OFS_MAX_FREQ 8'h1C
`define MSS_OFS_STATUS 8'h20
`define MSS_OFS_OUT_FREQ 8'h24
`define MSS_OFS_ACC_BASE 4'h3
`define MSS_CTRL_RUN 0
`define MSS_CTRL_DIR 1
`define MSS_CTRL_VF 2
`define MSS_CTRL_ASYNC 3
`define MSS_CFG_START_LSB 0
`define MSS_CFG_TRACK_LSB 2
`define MSS_CFG_SHAPE_LSB 4
`define MSS_CFG_RATE_LSB 8
`define MSS_BE_TIME_LSB 16
`define MSS_SC_END_LSB 16
`define MSS_RST_START_METHOD 2'h0
`define MSS_RST_TRACK_METHOD 2'h0
`define MSS_RST_SHAPE 2'h0
`define MSS_RST_TRACK_RATE 7'h14
`define MSS_RST_START_FREQ 10'h000
`define MSS_RST_TIME 10'h000
`define MSS_RST_CURRENT 7'h00
`define MSS_RST_RATIO 10'h12C
`define MSS_RST_MAX_FREQ 16'h1388
`define MSS_RST_TARGET 16'h0000
`define MSS_RST_ACC_TIME 10'h064
`define MSS_START_FREQ_MAX 10'h3E8
`define MSS_TIME_MAX 10'h3E8
`define MSS_RATIO_MAX 10'h3E8
`define MSS_PCT_MAX 7'h64
`define MSS_RATE_MIN 7'h01
`define MSS_RATE_MAX 7'h64
`define MSS_METHOD_DIRECT 2'h0
`define MSS_METHOD_TRACK 2'h1
`define MSS_METHOD_EXCITE 2'h2
`define MSS_TRACK_LAST 2'h0
`define MSS_TRACK_ZERO 2'h1
`define MSS_TRACK_MAX 2'h2
`define MSS_TRACK_PRESENT 2'h3
`define MSS_SHAPE_LINEAR 2'h0
`define MSS_W_FULL 7'h40
`define MSS_PCLK_HZ 40000000
`define MSS_TIME_UNIT_MS 100
`define MSS_MS_PER_S 1000
`define MSS_PERMILLE 1000
`define MSS_END_DIV 26'h7D0
`define MSS_PCT_DIV 23'h64
`endif

// *** rtl/mss_start_seq.v ***
// Motor start sequencer with APB register access
//
// The register addresses and register access over APB were left to the implementer.
`include "mss_defs.vh"
`default_nettype none
// Operation
// - Start method: 0 direct, 1 speed tracking, 2 pre-excitation; reset 0.
// - Direct start: nonzero brake time brakes first, then start frequency.
// - Tracking restart finds speed, direction; starts at tracked frequency.
// - Pre-excitation only for async motors; zero time skips magnetising.
// - Tracking search: last stop down, zero up, maximum down, present speed.
// - Present-speed tracking only in voltage-per-frequency control.
// - Tracking rate 1 to 100, default 20; larger is faster.
// - Start frequency 0.00 to 10.00 Hz, default zero, no lower-limit clamp.
// - Target below start frequency: stay in standby at zero output.
// - Hold start frequency for hold time, 0.0 to 100.0 s, then accelerate.
// - No start frequency hold during a direction reversal.
// - Hold excluded from acceleration time, counted as run time.
// - Start DC braking only in direct start, set current for set time.
// - Pre-excitation uses set current for set time, then runs.
// - Current base is motor rated, or 80% drive rated if smaller.
// - Shared current 0 to 100%, shared time 0.0 to 100.0 s, both default 0.
// - Ramp shape: 0 linear, 1 S-curve A, 2 S-curve B; the code runs every nonzero shape as S-curve A.
// - Linear ramps use one of four time sets picked by input terminals.
// - S-curve A uses start and end segment time fractions.
// - Slope grows in start segment, falls to zero in end segment.
// - Slope constant between the curved segments.
module mss_start_seq #(
	parameter DS_CYC = `MSS_PCLK_HZ / `MSS_MS_PER_S * `MSS_TIME_UNIT_MS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] accel_set_sel,
	input wire track_done,
	input wire [15:0] motor_freq_est,
	input wire motor_dir_est,
	input wire [15:0] motor_rated_current,
	input wire [15:0] drive_rated_current,
	output reg [15:0] out_freq,
	output reg out_dir,
	output reg [15:0] inject_current,
	output wire dc_brake_en,
	output wire excite_en,
	output wire track_search_en,
	output reg [15:0] track_start_freq,
	output reg track_down,
	output reg track_by_present,
	output wire [6:0] track_rate_out,
	output wire hold_active,
	output wire accel_active,
	output reg standby
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_BRAKE = 3'h1;
	localparam [2:0] ST_EXCITE = 3'h2;
	localparam [2:0] ST_TRACK = 3'h3;
	localparam [2:0] ST_HOLD = 3'h4;
	localparam [2:0] ST_RAMP = 3'h5;
	localparam [31:0] DS_U = DS_CYC - 1;
	localparam [21:0] DS_LAST = DS_U[21:0];
	localparam [39:0] DS_CYC_W = {8'h00, DS_U} + 40'h00_0000_0001;
	localparam [31:0] PM_U = DS_CYC / `MSS_PERMILLE;
	localparam [47:0] CYC_PER_PM = {16'h0000, PM_U};

	reg [3:0] ctrl;
	reg [1:0] start_method_sel;
	reg [1:0] track_method_sel;
	reg [1:0] ramp_shape_sel;
	reg [6:0] track_rate;
	reg [9:0] start_freq;
	reg [9:0] start_hold_time;
	reg [6:0] start_brake_excite_current;
	reg [9:0] start_brake_excite_time;
	reg [9:0] scurve_start_ratio;
	reg [9:0] scurve_end_ratio;
	reg [15:0] target_freq;
	reg [15:0] max_freq;
	reg [9:0] acc_time [0:3];
	reg [15:0] last_stop_freq;
	reg [2:0] state;
	reg [21:0] ds_div;
	reg [9:0] tcnt;
	reg [45:0] facc;
	reg [47:0] wacc;
	reg [6:0] w;

	wire run = ctrl[`MSS_CTRL_RUN];
	wire req_dir = ctrl[`MSS_CTRL_DIR];
	wire vf_mode = ctrl[`MSS_CTRL_VF];
	wire async_motor = ctrl[`MSS_CTRL_ASYNC];

	// APB decode, zero wait states
	wire acc_hit = (paddr[7:4] == `MSS_OFS_ACC_BASE) && (paddr[1:0] == 2'h0);
	reg mapped;
	always @* begin
		case (paddr)
			`MSS_OFS_CTRL, `MSS_OFS_CFG, `MSS_OFS_START_FREQ,
			`MSS_OFS_HOLD_TIME, `MSS_OFS_BRAKE_EXCITE, `MSS_OFS_SCURVE,
			`MSS_OFS_TARGET, `MSS_OFS_MAX_FREQ, `MSS_OFS_STATUS,
			`MSS_OFS_OUT_FREQ: mapped = 1'b1;
			default: mapped = acc_hit;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	wire wr_en = psel & penable & pwrite & mapped;

	always @* begin
		prdata = 32'h0000_0000;
		case (paddr)
			`MSS_OFS_CTRL: prdata[3:0] = ctrl;
			`MSS_OFS_CFG: prdata = {17'h0_0000, track_rate, 2'h0,
				ramp_shape_sel, track_method_sel, start_method_sel};
			`MSS_OFS_START_FREQ: prdata[9:0] = start_freq;
			`MSS_OFS_HOLD_TIME: prdata[9:0] = start_hold_time;
			`MSS_OFS_BRAKE_EXCITE: prdata = {6'h00, start_brake_excite_time,
				9'h000, start_brake_excite_current};
			`MSS_OFS_SCURVE: prdata = {6'h00, scurve_end_ratio, 6'h00,
				scurve_start_ratio};
			`MSS_OFS_TARGET: prdata[15:0] = target_freq;
			`MSS_OFS_MAX_FREQ: prdata[15:0] = max_freq;
			`MSS_OFS_STATUS: prdata = {last_stop_freq, 8'h00, 1'b0,
				hold_active, accel_active, standby, out_dir, state};
			`MSS_OFS_OUT_FREQ: prdata[15:0] = out_freq;
			default: if (acc_hit) prdata[9:0] = acc_time[paddr[3:2]];
		endcase
	end

	// Clamp helpers for written settings
	function [9:0] clamp10;
		input [31:0] v;
		input [9:0] lim;
		begin
			clamp10 = (v > {22'h00_0000, lim}) ? lim : v[9:0];
		end
	endfunction
	function [6:0] clamp7;
		input [31:0] v;
		input [6:0] lo;
		input [6:0] hi;
		begin
			clamp7 = (v > {25'h000_0000, hi}) ? hi :
				((v < {25'h000_0000, lo}) ? lo : v[6:0]);
		end
	endfunction
	wire [31:0] wd_cfg_rate = {25'h000_0000, pwdata[14:8]};
	wire [31:0] wd_hi = {22'h00_0000, pwdata[25:16]};
	wire [31:0] wd_lo7 = {25'h000_0000, pwdata[6:0]};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 4'h0;
			start_method_sel <= `MSS_RST_START_METHOD;
			track_method_sel <= `MSS_RST_TRACK_METHOD;
			ramp_shape_sel <= `MSS_RST_SHAPE;
			track_rate <= `MSS_RST_TRACK_RATE;
			start_freq <= `MSS_RST_START_FREQ;
			start_hold_time <= `MSS_RST_TIME;
			start_brake_excite_current <= `MSS_RST_CURRENT;
			start_brake_excite_time <= `MSS_RST_TIME;
			scurve_start_ratio <= `MSS_RST_RATIO;
			scurve_end_ratio <= `MSS_RST_RATIO;
			target_freq <= `MSS_RST_TARGET;
			max_freq <= `MSS_RST_MAX_FREQ;
		end else if (wr_en) begin
			case (paddr)
				`MSS_OFS_CTRL: ctrl <= pwdata[3:0];
				`MSS_OFS_CFG: begin
					start_method_sel <= pwdata[`MSS_CFG_START_LSB +: 2];
					track_method_sel <= pwdata[`MSS_CFG_TRACK_LSB +: 2];
					ramp_shape_sel <= pwdata[`MSS_CFG_SHAPE_LSB +: 2];
					track_rate <= clamp7(wd_cfg_rate, `MSS_RATE_MIN,
						`MSS_RATE_MAX);
				end
				`MSS_OFS_START_FREQ:
					start_freq <= clamp10(pwdata, `MSS_START_FREQ_MAX);
				`MSS_OFS_HOLD_TIME:
					start_hold_time <= clamp10(pwdata, `MSS_TIME_MAX);
				`MSS_OFS_BRAKE_EXCITE: begin
					start_brake_excite_current <= clamp7(wd_lo7, 7'h00,
						`MSS_PCT_MAX);
					start_brake_excite_time <= clamp10(wd_hi,
						`MSS_TIME_MAX);
				end
				`MSS_OFS_SCURVE: begin
					scurve_start_ratio <= clamp10(pwdata,
						`MSS_RATIO_MAX);
					scurve_end_ratio <= clamp10(wd_hi, `MSS_RATIO_MAX);
				end
				`MSS_OFS_TARGET: target_freq <= pwdata[15:0];
				`MSS_OFS_MAX_FREQ: max_freq <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// One time register per acceleration set
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_acc
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					acc_time[gi] <= `MSS_RST_ACC_TIME;
				else if (wr_en && acc_hit && paddr[3:2] == gi)
					acc_time[gi] <= clamp10(pwdata, `MSS_TIME_MAX);
			end
		end
	endgenerate

	// Injection current reference
	wire [17:0] drive_x4 = {drive_rated_current, 2'b00};
	wire [17:0] drive_80 = drive_x4 / 18'h0_0005;
	wire [15:0] cur_base = ({2'b00, motor_rated_current} <= drive_80) ?
		motor_rated_current : drive_80[15:0];
	wire [22:0] cur_prod = cur_base * start_brake_excite_current;
	wire [22:0] cur_ref = cur_prod / `MSS_PCT_DIV;

	// Ramp arithmetic
	wire [9:0] sel_time = acc_time[accel_set_sel];
	wire [39:0] period = sel_time * DS_CYC_W;
	wire [45:0] thresh = {period, 6'b00_0000};
	wire [47:0] t1_cyc = sel_time * scurve_start_ratio * CYC_PER_PM;
	wire [47:0] t2_cyc = sel_time * scurve_end_ratio * CYC_PER_PM;
	wire [25:0] end_prod = max_freq * scurve_end_ratio;
	wire [25:0] end_dist = end_prod / `MSS_END_DIV;
	wire reversing = (out_dir != req_dir);
	wire [15:0] goal = reversing ? 16'h0000 : target_freq;
	wire going_up = goal > out_freq;
	wire [15:0] remain = going_up ? goal - out_freq : out_freq - goal;
	wire [6:0] w_eff = (w == 7'h00) ? 7'h01 : w;
	wire [22:0] step_num = max_freq * w_eff;
	wire [45:0] next_facc = facc + {23'h00_0000, step_num};
	wire [47:0] next_wacc = wacc + {41'h000_0000_0000, `MSS_W_FULL};
	wire in_end_seg = ({10'h000, remain} <= end_dist);
	wire linear = (ramp_shape_sel == `MSS_SHAPE_LINEAR);
	wire ds_tick = (ds_div == DS_LAST);

	assign dc_brake_en = (state == ST_BRAKE);
	assign excite_en = (state == ST_EXCITE);
	assign track_search_en = (state == ST_TRACK);
	assign hold_active = (state == ST_HOLD);
	assign accel_active = (state == ST_RAMP) && (out_freq != goal);
	assign track_rate_out = track_rate;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			out_freq <= 16'h0000;
			out_dir <= 1'b0;
			standby <= 1'b0;
			last_stop_freq <= 16'h0000;
			ds_div <= 22'h00_0000;
			tcnt <= 10'h000;
			facc <= 46'h0;
			wacc <= 48'h0;
			w <= 7'h00;
			inject_current <= 16'h0000;
			track_start_freq <= 16'h0000;
			track_down <= 1'b0;
			track_by_present <= 1'b0;
		end else begin
			inject_current <= cur_ref[15:0];
			ds_div <= ds_tick ? 22'h00_0000 : ds_div + 22'h00_0001;
			if (ds_tick)
				tcnt <= tcnt + 10'h001;
			if (!run && state != ST_IDLE) begin
				state <= ST_IDLE;
				last_stop_freq <= out_freq;
				out_freq <= 16'h0000;
				standby <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					standby <= 1'b0;
					ds_div <= 22'h00_0000;
					tcnt <= 10'h000;
					facc <= 46'h0;
					wacc <= 48'h0;
					w <= linear ? `MSS_W_FULL : 7'h00;
					if (run) begin
						if (target_freq < {6'h00, start_freq}) begin
							standby <= 1'b1;
							out_freq <= 16'h0000;
						end else begin
							out_dir <= req_dir;
							case (start_method_sel)
							`MSS_METHOD_TRACK: begin
								state <= ST_TRACK;
								track_by_present <= 1'b0;
								track_down <= 1'b1;
								case (track_method_sel)
								`MSS_TRACK_ZERO: begin
									track_start_freq <= 16'h0000;
									track_down <= 1'b0;
								end
								`MSS_TRACK_MAX:
									track_start_freq <= max_freq;
								`MSS_TRACK_PRESENT: begin
									track_start_freq <= last_stop_freq;
									track_by_present <= vf_mode;
								end
								default: track_start_freq <= last_stop_freq;
								endcase
							end
							`MSS_METHOD_EXCITE: begin
								if (async_motor &&
									start_brake_excite_time != 10'h000)
									state <= ST_EXCITE;
								else begin
									state <= ST_HOLD;
									out_freq <= {6'h00, start_freq};
								end
							end
							default: begin
								if (start_brake_excite_time != 10'h000)
									state <= ST_BRAKE;
								else begin
									state <= ST_HOLD;
									out_freq <= {6'h00, start_freq};
								end
							end
							endcase
						end
					end
				end
				ST_BRAKE, ST_EXCITE: begin
					if (tcnt >= start_brake_excite_time) begin
						state <= ST_HOLD;
						out_freq <= {6'h00, start_freq};
						ds_div <= 22'h00_0000;
						tcnt <= 10'h000;
					end
				end
				ST_TRACK: begin
					if (track_done) begin
						state <= ST_RAMP;
						out_freq <= motor_freq_est;
						out_dir <= motor_dir_est;
					end
				end
				ST_HOLD: begin
					out_freq <= {6'h00, start_freq};
					if (tcnt >= start_hold_time)
						state <= ST_RAMP;
				end
				ST_RAMP: begin
					if (out_freq == goal) begin
						facc <= 46'h0;
						wacc <= 48'h0;
						w <= linear ? `MSS_W_FULL : 7'h00;
						if (reversing)
							out_dir <= req_dir;
					end else if (period == 40'h0) begin
						out_freq <= goal;
					end else begin
						if (next_facc >= thresh) begin
							facc <= next_facc - thresh;
							out_freq <= going_up ? out_freq + 16'h0001 :
								out_freq - 16'h0001;
						end else
							facc <= next_facc;
						if (linear)
							w <= `MSS_W_FULL;
						else if (in_end_seg) begin
							if (t2_cyc == 48'h0)
								w <= 7'h00;
							else if (next_wacc >= t2_cyc) begin
								wacc <= next_wacc - t2_cyc;
								if (w != 7'h00)
									w <= w - 7'h01;
							end else
								wacc <= next_wacc;
						end else if (w < `MSS_W_FULL) begin
							if (t1_cyc == 48'h0)
								w <= `MSS_W_FULL;
							else if (next_wacc >= t1_cyc) begin
								wacc <= next_wacc - t1_cyc;
								w <= w + 7'h01;
							end else
								wacc <= next_wacc;
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // mss_start_seq
`default_nettype wire

// *** verification/mss_props.sv ***
// Concurrent checks on the start sequencer ports
`default_nettype none
module mss_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] inject_current,
	input wire logic [15:0] motor_rated_current,
	input wire logic [15:0] drive_rated_current,
	input wire logic [6:0] track_rate_out,
	input wire logic dc_brake_en,
	input wire logic excite_en,
	input wire logic track_search_en,
	input wire logic hold_active,
	input wire logic accel_active,
	input wire logic standby
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_hold3;
		hold_active ##1 hold_active ##1 hold_active;
	endsequence
	sequence s_ramp2;
		accel_active ##1 accel_active;
	endsequence
	standby_zero_a:
		assert property (standby |-> out_freq == 16'h0000)
		else $error("standby with output running");
	hold_steady_a:
		assert property (s_hold3 |-> $stable(out_freq))
		else $error("output moved during hold");
	hold_no_accel_a:
		assert property (hold_active |-> !accel_active)
		else $error("ramp counted during hold");
	ramp_step_a:
		assert property (s_ramp2 |-> out_freq == $past(out_freq) ||
			out_freq == $past(out_freq) + 16'h0001 ||
			out_freq + 16'h0001 == $past(out_freq))
		else $error("ramp step larger than one");
	inject_no_freq_a:
		assert property (dc_brake_en || excite_en |-> out_freq == 16'h0000)
		else $error("output frequency during injection");
	rate_range_a:
		assert property (track_rate_out >= 7'h01 && track_rate_out <= 7'h64)
		else $error("tracking rate out of range");
	inject_base_a:
		assert property ($stable(motor_rated_current) &&
			$stable(drive_rated_current) |->
			inject_current <= motor_rated_current &&
			18'(inject_current) * 18'h5 <= 18'(drive_rated_current) * 18'h4)
		else $error("injection current above base");
	one_phase_a:
		assert property ($onehot0({dc_brake_en, excite_en, track_search_en,
			hold_active, accel_active}))
		else $error("two sequencer phases at once");
endmodule // mss_props
bind mss_start_seq mss_props u_props (.pclk(pclk), .presetn(presetn),
	.out_freq(out_freq), .inject_current(inject_current),
	.motor_rated_current(motor_rated_current),
	.drive_rated_current(drive_rated_current),
	.track_rate_out(track_rate_out), .dc_brake_en(dc_brake_en),
	.excite_en(excite_en), .track_search_en(track_search_en),
	.hold_active(hold_active), .accel_active(accel_active),
	.standby(standby));
`default_nettype wire

// *** verification/mss_stage_model.sv ***
// Power stage model answering speed tracking searches
`default_nettype none
module mss_stage_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic track_search_en,
	input wire logic [15:0] est,
	input wire logic [7:0] dly,
	output logic track_done,
	output logic [15:0] motor_freq_est,
	output logic motor_dir_est
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	// Estimates are junk unless done is reported
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			track_done <= 1'b0;
			motor_freq_est <= 16'h0000;
			motor_dir_est <= 1'b0;
		end else if (track_search_en && !track_done) begin
			cnt <= cnt + 8'h01;
			motor_freq_est <= ~motor_freq_est;
			if (cnt == dly) begin
				track_done <= 1'b1;
				motor_freq_est <= est;
				motor_dir_est <= 1'b0;
			end
		end else if (!track_search_en) begin
			cnt <= 8'h00;
			track_done <= 1'b0;
			motor_freq_est <= ~motor_freq_est;
			motor_dir_est <= ~motor_dir_est;
		end
	end
endmodule // mss_stage_model
`default_nettype wire

// *** verification/mss_start_seq_tb.sv ***
// Self-checking bench for the motor start sequencer
`default_nettype none
module mss_start_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DS = 40;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [7:0] paddr = 8'h00, dly = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic [1:0] sel = 2'h0;
	logic [15:0] mrc = 16'h0000, drc = 16'h0000, est = 16'h02BC;
	logic [15:0] out_freq, inject_current, track_start_freq, motor_freq_est;
	logic [6:0] track_rate_out;
	logic pready, pslverr, track_done, motor_dir_est, out_dir, dc_brake_en;
	logic excite_en, track_search_en, track_down, track_by_present;
	logic hold_active, accel_active, standby;
	wire [5:0] flg = {standby, accel_active, hold_active, track_search_en,
		excite_en, dc_brake_en};
	integer error_cnt = 0, checks = 0, cyc = 0, n, e, m, pct, last;
	integer acc[4];
	logic [7:0] ra[6] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h1C, 8'h30};
	logic [31:0] rv[6] = '{32'h1400, 32'h0, 32'h0, 32'h012C012C,
		32'h1388, 32'h64};
	mss_start_seq #(.DS_CYC(DS)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.accel_set_sel(sel), .track_done, .motor_freq_est, .motor_dir_est,
		.motor_rated_current(mrc), .drive_rated_current(drc), .out_freq,
		.out_dir, .inject_current, .dc_brake_en, .excite_en,
		.track_search_en, .track_start_freq, .track_down, .track_by_present,
		.track_rate_out, .hold_active, .accel_active, .standby);
	mss_stage_model u_stage (.pclk, .presetn, .track_search_en, .est, .dly,
		.track_done, .motor_freq_est, .motor_dir_est);
	initial forever #12.5 pclk = ~pclk;
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] x);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("Error at %0t got %h expected %h", $time, g, x);
		end
	endtask
	task apb(input bit w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wt(input int k, input bit v);
		#1;
		n = 0;
		while (flg[k] !== v && n < 9000) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(n < 9000, 1);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		void'($urandom(32'h4AA2));
		repeat (12) @(posedge pclk);
		presetn <= 1;
		foreach (ra[i]) begin
			apb(0, ra[i], 0);
			chk(rd, rv[i]);
		end
		apb(0, 8'h40, 0);
		chk(se, 1);
		chk(pready, 1);
		apb(1, 8'h04, 32'h0);
		apb(0, 8'h04, 0);
		chk(rd, 32'h0100);
		apb(1, 8'h04, 32'h7F00);
		apb(0, 8'h04, 0);
		chk(track_rate_out, 7'h64);
		apb(1, 8'h08, 32'h07D0);
		apb(0, 8'h08, 0);
		chk(rd, 32'h03E8);
		apb(1, 8'h08, 32'h01F4);
		apb(1, 8'h0C, 32'h1);
		for (int i = 0; i < 4; i++) begin
			acc[i] = 150 + 50 * i;
			apb(1, 8'h30 + 8'(4 * i), acc[i]);
		end
		apb(1, 8'h18, 32'h00C8);
		apb(1, 8'h00, 32'h1);
		wt(5, 1);
		chk(out_freq, 0);
		apb(1, 8'h00, 0);
		drc <= 16'($urandom_range(2000, 1000));
		mrc <= 16'($urandom_range(2000, 1000));
		sel <= 2'($urandom_range(3, 0));
		pct = $urandom_range(100, 1);
		apb(1, 8'h10, {6'h0, 10'h002, 9'h000, 7'(pct)});
		apb(1, 8'h04, 32'h1400);
		apb(1, 8'h18, 32'h03E8);
		apb(1, 8'h00, 32'h1);
		wt(0, 1);
		apb(1, 8'h00, 0);
		wt(0, 0);
		chk(out_freq, 0);
		apb(1, 8'h00, 32'h1);
		wt(0, 1);
		e = (mrc < drc * 4 / 5) ? mrc : drc * 4 / 5;
		chk(inject_current, e * pct / 100);
		wt(3, 1);
		chk(out_freq, 16'h01F4);
		wt(3, 0);
		chk(n >= DS - 3 && n <= DS + 3, 1);
		wt(4, 0);
		e = 500 * acc[sel] * DS / 5000;
		chk(n >= e - e / 20 - 4 && n <= e + e / 20 + 4, 1);
		chk(out_freq, 16'h03E8);
		apb(1, 8'h00, 0);
		last = 1000;
		for (m = 0; m < 5; m++) begin
			est <= 16'($urandom_range(800, 600));
			dly <= 8'($urandom_range(60, 0));
			apb(1, 8'h04, 32'h1401 | (m == 4 ? 3 : m) << 2);
			apb(1, 8'h18, est);
			apb(1, 8'h00, {29'h0, m != 4, 2'h1});
			wt(2, 1);
			chk(track_by_present, m == 3);
			if (m != 3) begin
				chk(track_start_freq, m == 1 ? 0 : m == 2 ? 5000 : last);
				chk(track_down, m != 1);
			end
			wt(2, 0);
			chk(out_freq, est);
			chk(out_dir, 0);
			apb(1, 8'h00, 0);
			last = est;
		end
		mrc <= drc / 2;
		apb(1, 8'h10, {6'h0, 10'h001, 9'h000, 7'(pct)});
		apb(1, 8'h04, 32'h1402);
		apb(1, 8'h00, 32'h9);
		wt(1, 1);
		chk(inject_current, mrc * pct / 100);
		wt(3, 1);
		chk(out_freq, 16'h01F4);
		apb(1, 8'h00, 0);
		apb(1, 8'h00, 32'h1);
		wt(3, 1);
		chk(n < 5, 1);
		apb(1, 8'h00, 0);
		apb(1, 8'h10, 0);
		apb(1, 8'h14, 32'h0000_0190);
		apb(0, 8'h14, 0);
		chk(rd, 32'h0000_0190);
		apb(1, 8'h04, 32'h1410);
		apb(1, 8'h00, 32'h1);
		wt(3, 1);
		chk(n < 5, 1);
		wt(3, 0);
		wt(4, 0);
		e = (last - 500) * acc[sel] * DS / 5000;
		chk(n >= e - e / 20 - 4 && n <= e + e / 20 + 4, 1);
		chk(out_freq, last);
		tally_and_finish;
	end
endmodule // mss_start_seq_tb
`default_nettype wire
